// ===== core/cri_reset_init.sv
// reset acceptance, vector fetch and cpu/peripheral initialization
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RL1) source holds reset low ten clocks
// (RL2) source asserts reset after oscillator settles
// (RL3) program counter built from three vector bytes
// (RL4) stack pointer preset to 100H
// (RL5) interrupt mask level set to seven
// (RL6) wide mode bit set to one
// (RL7) software never clears the wide bit
// (RL8) bank select cleared to zero
// (RL9) fetch starts at vector after release
// (RL10) other cpu registers keep their contents
// (RL11) peripheral registers return to initial values
// (RL12) port pins revert to plain ports
// (RL13) clock output held high in reset
// (RL14) io space decoded at 000000H..00009FH
// (RL15) io area reachable by short addressing
// (RL16) clock output is oscillator divided four
// (RL17) reset sampled and low samples counted
module cri_reset_init
   import cri_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic reset_pin_n_in,
   input wire logic [7:0] vec_rdata_in,
   input wire logic sw_sw_we_in,
   input wire logic [31:0] sw_sp_in,
   input wire cri_status_word_t sw_status_in,
   input wire logic [23:0] cpu_addr_in,
   input wire logic cpu_short_in,
   input wire logic [7:0] cpu_short_addr_in,
   output logic [23:0] vec_addr_out,
   output logic vec_rd_out,
   output logic [23:0] program_counter_out,
   output logic [31:0] system_stack_pointer_out,
   output cri_status_word_t status_word_out,
   output logic fetch_en_out,
   output logic periph_init_out,
   output logic [PIN_COUNT-1:0] port_mode_gpio_out,
   output logic clk_out,
   output logic io_sel_out,
   output logic [7:0] io_offset_out
);

   // ********************
   // reset acceptance
   // ********************
   logic [3:0] low_cnt;
   logic [3:0] next_low_cnt;
   logic accepted;

   cri_state_t state;
   cri_state_t next_state;
   logic warm;
   logic next_warm;

   logic [23:0] pc;
   logic [23:0] next_pc;
   logic [31:0] sp;
   logic [31:0] next_sp;
   cri_status_word_t sw;
   cri_status_word_t next_sw;

   logic [1:0] div;
   logic [1:0] next_div;
   logic clk_q;
   logic next_clk_q;

   logic [23:0] eff_addr;

   // reset sequence in progress: taking a reset, or any state but run
   function automatic logic seq_active(input cri_state_t st, input logic acc);
      return (st != CRI_RUN) || acc;
   endfunction

   // io window test shared by the select and the offset
   function automatic logic in_io_window(input logic [23:0] a);
      return (a >= IO_BASE) && (a <= IO_LAST);
   endfunction

   // any high sample restarts the count, so short glitches never add up
   // (RL17) count low samples
   always_comb begin
      next_low_cnt = low_cnt;
      if (reset_pin_n_in) begin
         next_low_cnt = 4'h0;
      end else if (low_cnt != RST_CNT_W_MAX) begin
         next_low_cnt = low_cnt + 4'h1;
      end
   end

   // (RL1) ten low samples needed
   assign accepted = (low_cnt == RST_CNT_W_MAX);

   // ********************
   // sequencer
   // ********************
   // warm is low only in the first cycle after power-up
   always_comb begin
      next_warm = 1'h1;
   end

   always_comb begin
      next_state = state;
      case (state)
         CRI_RUN: begin
            if (accepted) begin
               next_state = CRI_HOLD;
            end
         end
         CRI_HOLD: begin
            // after power-up the low byte address has only just gone out, so wait a cycle
            if (warm) begin
               next_state = CRI_VEC0;
            end
         end
         CRI_VEC0: begin
            next_state = CRI_VEC1;
         end
         CRI_VEC1: begin
            // (RL9) wait for release, vector reread while held
            if (reset_pin_n_in) begin
               next_state = CRI_RUN;
            end else begin
               next_state = CRI_HOLD;
            end
         end
         default: begin
            next_state = CRI_HOLD;
         end
      endcase
   end

   // vector byte address follows the sequencer; data arrives one cycle later
   always_comb begin
      case (state)
         CRI_RUN: begin
            vec_addr_out = VEC_ADDR_LO;
         end
         CRI_HOLD: begin
            vec_addr_out = warm ? VEC_ADDR_MID : VEC_ADDR_LO;
         end
         CRI_VEC0: begin
            vec_addr_out = VEC_ADDR_HI;
         end
         default: begin
            vec_addr_out = VEC_ADDR_LO;
         end
      endcase
   end
   assign vec_rd_out = seq_active(state, accepted);

   // ********************
   // cpu register presets
   // ********************
   // only pc, sp and the three status fields move; other cpu state is untouched
   always_comb begin
      next_pc = pc;
      next_sp = sp;
      next_sw = sw;
      case (state)
         CRI_RUN: begin
            // software loads are dropped once a reset is being taken
            if (!accepted && sw_sw_we_in) begin
               next_sp = sw_sp_in;
               next_sw = sw_status_in;
               // (RL7) wide bit stays set
               next_sw.wide_mode = WIDE_MODE_RESET;
            end
         end
         CRI_HOLD: begin
            if (warm) begin
               // (RL3) low vector byte
               next_pc[7:0] = vec_rdata_in;
            end
            // (RL4) stack pointer preset
            next_sp = SP_RESET;
            // (RL5) mask level seven
            next_sw.irq_mask_level = IRQ_MASK_RESET;
            // (RL6) wide mode set
            next_sw.wide_mode = WIDE_MODE_RESET;
            // (RL8) bank zero
            next_sw.bank_select_field = BANK_RESET;
         end
         CRI_VEC0: begin
            // (RL3) middle vector byte
            next_pc[15:8] = vec_rdata_in;
         end
         CRI_VEC1: begin
            // (RL3) high vector byte
            next_pc[23:16] = vec_rdata_in;
         end
         default: begin
            next_pc = pc;
         end
      endcase
   end

   // ********************
   // clock output divider
   // ********************
   // (RL16) divide by four
   always_comb begin
      if (seq_active(state, accepted)) begin
         // (RL13) held high in reset
         next_div = 2'h0;
         next_clk_q = 1'h1;
      end else begin
         next_div = div + 2'h1;
         next_clk_q = (div < CLK_DIV_HALF);
      end
   end

   // acceptance counter clears on power-up
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_cnt <= 4'h0;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end

   // power-up lands in hold so the presets run once before any fetch
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= CRI_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // clock output starts high
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div <= 2'h0;
         clk_q <= 1'h1;
      end else begin
         div <= next_div;
         clk_q <= next_clk_q;
      end
   end

   // marks the first cycle after power-up
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         warm <= 1'h0;
      end else begin
         warm <= next_warm;
      end
   end

   // (RL10) pc, sp and status reset only via the sequencer, not rstn
   always_ff @(posedge core_clk_in) begin
      pc <= next_pc;
      sp <= next_sp;
      sw <= next_sw;
   end

   assign program_counter_out = pc;
   assign system_stack_pointer_out = sp;
   assign status_word_out = sw;
   assign clk_out = clk_q;

   // (RL9) fetch from vector after release
   assign fetch_en_out = !seq_active(state, accepted);
   // (RL11) peripherals held at init
   assign periph_init_out = seq_active(state, accepted);

   // ********************
   // port modes and io decode
   // ********************
   // pin modes follow the init level, so they let go once run resumes
   // (RL12) every pin to plain port
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : g_pin
         assign port_mode_gpio_out[g] = periph_init_out;
      end
   endgenerate

   // (RL15) short form zero-extends
   always_comb begin
      if (cpu_short_in) begin
         eff_addr = {16'h0000, cpu_short_addr_in};
      end else begin
         eff_addr = cpu_addr_in;
      end
   end

   // addresses outside the window give offset zero, not a wrapped index
   // (RL14) io window decode
   always_comb begin
      io_sel_out = in_io_window(eff_addr);
      io_offset_out = 8'h00;
      if (in_io_window(eff_addr)) begin
         io_offset_out = eff_addr[7:0];
      end
   end

endmodule // cri_reset_init

`default_nettype wire

// ===== core/cri_pkg.sv
// package for the cpu reset and initialization block
package cri_pkg;
   localparam int RST_MIN_CYCLES = 10;
   localparam logic [3:0] RST_CNT_W_MAX = 4'hA;
   localparam logic [23:0] VEC_ADDR_LO = 24'hFFFF00;
   localparam logic [23:0] VEC_ADDR_MID = 24'hFFFF01;
   localparam logic [23:0] VEC_ADDR_HI = 24'hFFFF02;
   localparam logic [31:0] SP_RESET = 32'h00000100;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h7;
   localparam logic WIDE_MODE_RESET = 1'h1;
   localparam logic [2:0] BANK_RESET = 3'h0;
   localparam logic [23:0] IO_BASE = 24'h000000;
   localparam logic [23:0] IO_LAST = 24'h00009F;
   localparam logic [7:0] IO_SHORT_MAX = 8'hFF;
   localparam int CLK_DIV = 4;
   localparam logic [1:0] CLK_DIV_LAST = 2'h3;
   localparam logic [1:0] CLK_DIV_HALF = 2'h2;
   localparam int PIN_COUNT = 8;

   typedef struct packed {
      logic wide_mode;
      logic [2:0] irq_mask_level;
      logic [2:0] bank_select_field;
   } cri_status_word_t;

   typedef enum logic [3:0] {
      CRI_RUN = 4'h1,
      CRI_HOLD = 4'h2,
      CRI_VEC0 = 4'h4,
      CRI_VEC1 = 4'h8
   } cri_state_t;
endpackage : cri_pkg

// ===== verification/cri_sva.sv
// assertions on the ports of the reset and initialization block
`timescale 1ns/10ps
`default_nettype none
module cri_sva
   import cri_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic reset_pin_n_in,
   input wire logic [23:0] cpu_addr_in,
   input wire logic cpu_short_in,
   input wire logic [31:0] system_stack_pointer_out,
   input wire cri_status_word_t status_word_out,
   input wire logic fetch_en_out,
   input wire logic periph_init_out,
   input wire logic [PIN_COUNT-1:0] port_mode_gpio_out,
   input wire logic clk_out,
   input wire logic io_sel_out
);
   logic [3:0] n;
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);
   // saturating count of low pin samples, the design's own count is unseen
   always_ff @(posedge core_clk_in or negedge rstn_in)
      if (!rstn_in) n <= 4'h0;
      else n <= reset_pin_n_in ? 4'h0 : n + {3'h0, n != 4'hF};
   property p_acc; n == 4'hA |-> !fetch_en_out; endproperty
   a_acc: assert property (p_acc) else $error("fetch kept after accept");
   property p_sp; n == 4'hA |-> ##3 system_stack_pointer_out == SP_RESET; endproperty
   a_sp: assert property (p_sp) else $error("stack pointer not preset");
   property p_mask; n == 4'hA |-> ##3 status_word_out.irq_mask_level == 3'h7; endproperty
   a_mask: assert property (p_mask) else $error("mask not seven");
   property p_wide; n == 4'hA |-> ##3 status_word_out.wide_mode; endproperty
   a_wide: assert property (p_wide) else $error("wide bit clear");
   property p_bank; n == 4'hA |-> ##3 status_word_out.bank_select_field == 3'h0; endproperty
   a_bank: assert property (p_bank) else $error("bank not zero");
   property p_gpio; n == 4'hA |=> &port_mode_gpio_out; endproperty
   a_gpio: assert property (p_gpio) else $error("pins not plain ports");
   property p_init; n == 4'hA |=> periph_init_out; endproperty
   a_init: assert property (p_init) else $error("peripherals not held at init");
   property p_clkhi; periph_init_out |=> clk_out; endproperty
   a_clkhi: assert property (p_clkhi) else $error("clock output low in reset");
   property p_io; !cpu_short_in |-> io_sel_out == (cpu_addr_in <= IO_LAST); endproperty
   a_io: assert property (p_io) else $error("io decode wrong");
   // margin of five run cycles covers the forced high phase
   property p_div; !periph_init_out [*5] |-> clk_out != $past(clk_out, 2); endproperty
   a_div: assert property (p_div) else $error("clock output not divided by four");
endmodule // cri_sva
`default_nettype wire

// ===== verification/cri_src.sv
// reset source and vector memory facing the block
`timescale 1ns/10ps
`default_nettype none
module cri_src #(parameter logic [23:0] VEC = 24'h000000) (
   input wire logic clk_in,
   input wire logic [23:0] addr_in,
   input wire logic rd_in,
   output logic [7:0] data_out,
   output logic pin_n_out
);
   initial pin_n_out = 1'h1;
   initial data_out = 8'h00;
   // bytes one cycle late, bus garbage when idle
   always @(posedge clk_in)
      data_out <= !rd_in ? ~data_out : addr_in == 24'hFFFF00 ? VEC[7:0] :
         addr_in == 24'hFFFF01 ? VEC[15:8] : addr_in == 24'hFFFF02 ? VEC[23:16] : ~data_out;
   // low for n clocks, only once the clock runs
   task pulse(input int n);
      @(negedge clk_in);
      pin_n_out = 1'h0;
      repeat (n) @(negedge clk_in);
      pin_n_out = 1'h1;
   endtask
endmodule // cri_src
`default_nettype wire

// ===== verification/cri_reset_init_tb.sv
// testbench for the reset and initialization block
`timescale 1ns/10ps
`default_nettype none
module cri_reset_init_tb;
   import cri_pkg::*;
   localparam logic [23:0] VEC = 24'h5AC31E;
   logic core_clk_in, rstn_in, reset_pin_n_in, sw_sw_we_in, cpu_short_in, vec_rd_out;
   logic fetch_en_out, periph_init_out, clk_out, io_sel_out, low;
   logic [7:0] vec_rdata_in, cpu_short_addr_in, io_offset_out;
   logic [23:0] cpu_addr_in, vec_addr_out, program_counter_out;
   logic [23:0] io_tbl[4] = '{24'h000000, 24'h00009F, 24'h0000A0, 24'hFFFF02};
   logic [31:0] sw_sp_in, system_stack_pointer_out;
   logic [PIN_COUNT-1:0] port_mode_gpio_out;
   cri_status_word_t sw_status_in, status_word_out;
   int err_count, num_checks, cyc;
   cri_reset_init DUT (.*);
   cri_src #(.VEC(VEC)) u_src (.clk_in(core_clk_in), .addr_in(vec_addr_out),
      .rd_in(vec_rd_out), .data_out(vec_rdata_in), .pin_n_out(reset_pin_n_in));
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e);
      end
   endtask
   task stop_test;
      if (err_count == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task go;
      for (int i = 0; i < 40 && fetch_en_out !== 1'h1; i++) @(negedge core_clk_in);
      chk(fetch_en_out, 1);
   endtask
   initial begin
      core_clk_in = 1'h0;
      forever #4 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         stop_test;
      end
   end
   initial begin
      {rstn_in, sw_sw_we_in, cpu_short_in, cpu_short_addr_in, cpu_addr_in} = '0;
      sw_sp_in = 32'h0;
      sw_status_in = '0;
      repeat (4) @(negedge core_clk_in);
      rstn_in = 1'h1;
      go;
      chk(program_counter_out, VEC);
      low = 1'h0;
      fork
         u_src.pulse(9);
         repeat (12) @(negedge core_clk_in) low |= !fetch_en_out;
      join
      chk(low, 0);
      u_src.pulse(10);
      go;
      chk(program_counter_out, VEC);
      @(negedge core_clk_in);
      sw_sw_we_in = 1'h1;
      sw_sp_in = 32'h0000BEEF;
      sw_status_in = '{1'h0, 3'h3, 3'h5};
      @(negedge core_clk_in);
      sw_sw_we_in = 1'h0;
      chk(status_word_out, 32'h5D);
      chk(system_stack_pointer_out, 32'hBEEF);
      u_src.pulse(12);
      go;
      chk(system_stack_pointer_out, SP_RESET);
      chk(status_word_out, {WIDE_MODE_RESET, IRQ_MASK_RESET, BANK_RESET});
      chk(program_counter_out, VEC);
      foreach (io_tbl[i]) begin
         @(negedge core_clk_in);
         cpu_addr_in = io_tbl[i];
         #1 chk(io_sel_out, io_tbl[i] <= IO_LAST);
      end
      cpu_short_in = 1'h1;
      cpu_short_addr_in = 8'h9F;
      #1 chk({io_sel_out, io_offset_out}, 32'h19F);
      cpu_short_addr_in = 8'hA0;
      #1 chk(io_sel_out, 0);
      stop_test;
   end
endmodule // cri_reset_init_tb
bind cri_reset_init cri_sva u_sva (.*);
`default_nettype wire
